//--- spfpe_busy_timer.sv
// Self-timed operation counter for program and erase cycles
`timescale 1ns/1ps
module spfpe_busy_timer #(
  parameter int CNT_W = 27
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [CNT_W-1:0] cycles,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        cnt_reg <= cycles;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt_reg <= CNT_W'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end
endmodule : spfpe_busy_timer

//--- spfpe_core.sv
// Program, erase and burst-wrap instruction handling of a serial flash
`timescale 1ns/1ps
module spfpe_core
  import spfpe_pkg::*;
#(
  parameter int PAGE_PROG_CYC = PAGE_PROG_US * CLK_MHZ,
  parameter int SECT_ERASE_CYC = SECT_ERASE_US * CLK_MHZ,
  parameter int BLK32_ERASE_CYC = BLK32_ERASE_US * CLK_MHZ,
  parameter int BLK64_ERASE_CYC = BLK64_ERASE_US * CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io_in,
  input wire logic quad_enable,
  input wire logic wel_set,
  input wire logic target_protected,
  input wire logic [23:0] read_start_addr,
  input wire logic read_step,
  output logic write_enable_latch,
  output logic busy,
  output logic [2:0] wrap_config_bits,
  output logic [23:0] read_addr,
  output logic op_start,
  output logic [1:0] op_kind,
  output logic [23:0] op_addr,
  output logic page_wr_en,
  output logic [7:0] page_wr_idx,
  output logic [7:0] page_wr_data,
  output logic [23:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata
);
  import spfpe_pkg::*;

  localparam int CNT_W = 27;
  if (BLK64_ERASE_CYC >= (1 << CNT_W) || PAGE_PROG_CYC < 1)
  begin : g_bad_count
    $error("spfpe_core: erase or program count out of range");
  end

  // ----------------------------------------------------------------
  // Link domain: shift in bits, clocked by spi_clk, reset by select
  // ----------------------------------------------------------------
  logic [7:0] sh_reg;
  logic [2:0] bitc_reg;
  logic [5:0] byte_cnt_reg;
  logic [7:0] opc_reg;
  logic [23:0] addr_reg;
  logic [8:0] nbytes_reg;
  logic [7:0] wrap_byte_reg;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] pidx_reg;
  logic quad_mode;
  logic [7:0] sh_next;
  logic [2:0] step;
  logic fresh_reg;
  logic [2:0] bitc_cur;
  logic [5:0] byte_cur;
  logic [8:0] nbytes_cur;
  logic byte_end;

  // Counters restart on the first clock of a frame and stay frozen after it,
  // so the core side can read the frame summary once select is high
  assign bitc_cur = fresh_reg ? 3'h0 : bitc_reg;
  assign byte_cur = fresh_reg ? 6'h0 : byte_cnt_reg;
  assign nbytes_cur = fresh_reg ? 9'h0 : nbytes_reg;
  assign quad_mode = (opc_reg == OP_QUAD_PROG) && (byte_cur != 6'h0);
  assign step = quad_mode ? 3'h4 : 3'h1;
  assign byte_end = (bitc_cur + step) == 3'h0;
  assign sh_next = quad_mode ? {sh_reg[3:0], spi_io_in} : {sh_reg[6:0], spi_io_in[0]};

  always_ff @(posedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      fresh_reg <= 1'b1;
    else
      fresh_reg <= 1'b0;
  end

  always_ff @(posedge spi_clk)
  begin
    if (!spi_cs_n)
    begin
      sh_reg <= sh_next;
      bitc_reg <= bitc_cur + step;
      byte_cnt_reg <= byte_cur;
      nbytes_reg <= nbytes_cur;
      if (byte_end)
      begin
        if (byte_cur != 6'h3f)
          byte_cnt_reg <= byte_cur + 6'h1;
        if (byte_cur >= 6'h4 && nbytes_cur != 9'h100)
          nbytes_reg <= nbytes_cur + 9'h1;
      end
    end
  end

  // Opcode, address and wrap byte capture
  always_ff @(posedge spi_clk)
  begin
    if (!spi_cs_n && byte_end)
    begin
      case (byte_cur)
        6'h0: opc_reg <= sh_next;
        6'h1: addr_reg[23:16] <= sh_next;
        6'h2: addr_reg[15:8] <= sh_next;
        6'h3: addr_reg[7:0] <= sh_next;
        6'h4:
        begin
          if (opc_reg == OP_WRAP_SET)
            wrap_byte_reg <= sh_next;
        end
        default: ;
      endcase
    end
  end

  // Page data buffer, address wraps inside the page
  always_ff @(posedge spi_clk)
  begin
    if (!spi_cs_n && byte_end && byte_cur == 6'h3)
      pidx_reg <= sh_next;
    else if (!spi_cs_n && byte_end && byte_cur >= 6'h4)
    begin
      pbuf[pidx_reg] <= sh_next;
      pidx_reg <= pidx_reg + 8'h1;
    end
  end

  // Whole-byte flag at select rise: level in link domain
  logic frame_ok;
  assign frame_ok = (bitc_reg == 3'h0);

  // ----------------------------------------------------------------
  // Crossings into core_clk
  // ----------------------------------------------------------------
  logic [2:0] cs_sync_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cs_sync_reg <= 3'h7;
    else
      cs_sync_reg <= {cs_sync_reg[1:0], spi_cs_n};
  end

  // A frame with no clocks at all leaves the previous summary in place
  logic cs_rise;
  logic wrap_evt;
  assign cs_rise = cs_sync_reg[1] && !cs_sync_reg[2];
  assign wrap_evt = cs_rise && (opc_reg == OP_WRAP_SET) && (byte_cnt_reg >= 6'h5);

  // ----------------------------------------------------------------
  // Wrap configuration
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wrap_config_bits <= WRAP_CFG_RESET;
    else if (wrap_evt)
      wrap_config_bits <= wrap_byte_reg[6:4];
  end

  // ----------------------------------------------------------------
  // Quad read address with section wrap
  // ----------------------------------------------------------------
  logic [5:0] sect_mask;
  always_comb
  begin
    case (wrap_config_bits[2:1])
      2'h0: sect_mask = 6'h07;
      2'h1: sect_mask = 6'h0f;
      2'h2: sect_mask = 6'h1f;
      default: sect_mask = 6'h3f;
    endcase
  end

  logic [23:0] inc_addr;
  assign inc_addr = read_addr + 24'h1;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      read_addr <= '0;
    else if (read_step)
    begin
      if (!wrap_config_bits[0])
        read_addr <= {read_addr[23:6], (read_addr[5:0] & ~sect_mask) | (inc_addr[5:0] & sect_mask)};
      else
        read_addr <= inc_addr;
    end
    else
      read_addr <= read_start_addr;
  end

  // ----------------------------------------------------------------
  // Command decode at select rise
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPFPE_IDLE, SPFPE_COPY, SPFPE_ERASE, SPFPE_WAIT} spfpe_st_t;
  spfpe_st_t st_reg;
  logic tmr_busy;
  logic tmr_done;
  logic tmr_start;
  logic [CNT_W-1:0] tmr_cycles;
  logic [8:0] cp_reg;
  logic [8:0] cp_tot_reg;
  logic [7:0] base_idx_reg;
  logic [23:0] er_cnt_reg;
  logic [23:0] er_len;
  logic accept;
  logic prog_cmd;
  logic erase_cmd;

  assign prog_cmd = (opc_reg == OP_PAGE_PROG) || (opc_reg == OP_QUAD_PROG && quad_enable);
  assign erase_cmd = (opc_reg == OP_SECT_ERASE) || (opc_reg == OP_BLK32_ERASE)
    || (opc_reg == OP_BLK64_ERASE);
  // Select-rise fields are stable: link domain is frozen while select is high
  assign accept = cs_rise && frame_ok && write_enable_latch && !target_protected && !busy
    && ((prog_cmd && nbytes_reg != 9'h0) || (erase_cmd && byte_cnt_reg == 6'h4));

  always_comb
  begin
    case (op_kind)
      SPFPE_OP_SECT: er_len = ~SECT_MASK + 24'h1;
      SPFPE_OP_B32: er_len = ~BLK32_MASK + 24'h1;
      default: er_len = ~BLK64_MASK + 24'h1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= SPFPE_IDLE;
      op_start <= 1'b0;
      op_kind <= SPFPE_OP_PROG;
      op_addr <= '0;
      cp_reg <= '0;
      cp_tot_reg <= '0;
      base_idx_reg <= '0;
      er_cnt_reg <= '0;
      tmr_cycles <= '0;
      tmr_start <= 1'b0;
    end
    else
    begin
      op_start <= 1'b0;
      tmr_start <= 1'b0;
      case (st_reg)
        SPFPE_IDLE:
        begin
          if (accept)
          begin
            op_start <= 1'b1;
            if (prog_cmd)
            begin
              op_kind <= SPFPE_OP_PROG;
              op_addr <= addr_reg;
              base_idx_reg <= addr_reg[7:0];
              cp_reg <= (nbytes_reg > 9'(PAGE_BYTES)) ? 9'(PAGE_BYTES) : nbytes_reg;
              cp_tot_reg <= (nbytes_reg > 9'(PAGE_BYTES)) ? 9'(PAGE_BYTES) : nbytes_reg;
              tmr_cycles <= CNT_W'(PAGE_PROG_CYC);
              st_reg <= SPFPE_COPY;
            end
            else
            begin
              er_cnt_reg <= '0;
              st_reg <= SPFPE_ERASE;
              if (opc_reg == OP_SECT_ERASE)
              begin
                op_kind <= SPFPE_OP_SECT;
                op_addr <= addr_reg & SECT_MASK;
                tmr_cycles <= CNT_W'(SECT_ERASE_CYC);
              end
              else if (opc_reg == OP_BLK32_ERASE)
              begin
                op_kind <= SPFPE_OP_B32;
                op_addr <= addr_reg & BLK32_MASK;
                tmr_cycles <= CNT_W'(BLK32_ERASE_CYC);
              end
              else
              begin
                op_kind <= SPFPE_OP_B64;
                op_addr <= addr_reg & BLK64_MASK;
                tmr_cycles <= CNT_W'(BLK64_ERASE_CYC);
              end
            end
          end
        end
        SPFPE_COPY:
        begin
          if (cp_reg != 9'h0)
            cp_reg <= cp_reg - 9'h1;
          else
          begin
            st_reg <= SPFPE_WAIT;
            tmr_start <= 1'b1;
          end
        end
        SPFPE_ERASE:
        begin
          // Timer starts after the sweep so its done pulse is seen in WAIT
          if (er_cnt_reg == er_len - 24'h1)
          begin
            st_reg <= SPFPE_WAIT;
            tmr_start <= 1'b1;
          end
          else
            er_cnt_reg <= er_cnt_reg + 24'h1;
        end
        SPFPE_WAIT:
        begin
          if (tmr_done)
            st_reg <= SPFPE_IDLE;
        end
        default: st_reg <= SPFPE_IDLE;
      endcase
    end
  end

  // Memory write port: only loaded bytes written, erase fills FFh
  logic [7:0] cp_idx;
  assign cp_idx = base_idx_reg + 8'(cp_tot_reg - cp_reg);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      page_wr_en <= 1'b0;
      page_wr_idx <= '0;
      page_wr_data <= '0;
    end
    else
    begin
      mem_we <= 1'b0;
      page_wr_en <= 1'b0;
      if (st_reg == SPFPE_COPY && cp_reg != 9'h0)
      begin
        mem_we <= 1'b1;
        mem_addr <= {op_addr[23:8], cp_idx};
        mem_wdata <= pbuf[cp_idx];
        page_wr_en <= 1'b1;
        page_wr_idx <= cp_idx;
        page_wr_data <= pbuf[cp_idx];
      end
      else if (st_reg == SPFPE_ERASE)
      begin
        mem_we <= 1'b1;
        mem_addr <= op_addr | er_cnt_reg;
        mem_wdata <= ERASED_BYTE;
      end
    end
  end

  spfpe_busy_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .cycles(tmr_cycles),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      write_enable_latch <= 1'b0;
    end
    else
    begin
      busy <= accept || (st_reg != SPFPE_IDLE) || op_start;
      if (tmr_done && st_reg == SPFPE_WAIT)
        write_enable_latch <= 1'b0;
      else if (wel_set)
        write_enable_latch <= 1'b1;
    end
  end
endmodule : spfpe_core

//--- spfpe_core_sva.sv
// Concurrent checks on the ports of the program, erase and wrap core
`timescale 1ns/1ps
module spfpe_core_sva
  import spfpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic target_protected,
  input wire logic read_step,
  input wire logic write_enable_latch,
  input wire logic busy,
  input wire logic [2:0] wrap_config_bits,
  input wire logic [23:0] read_addr,
  input wire logic op_start,
  input wire logic [1:0] op_kind,
  input wire logic [23:0] op_addr,
  input wire logic mem_we
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  chk_wrap_default: assert property ($rose(rst_n) |-> wrap_config_bits == WRAP_CFG_RESET)
    else $error("wrap setting not at default after reset");
  chk_start_wel: assert property (op_start |-> write_enable_latch)
    else $error("operation started without write enable");
  chk_start_prot: assert property (op_start |-> !target_protected)
    else $error("operation started on protected target");
  chk_start_idle: assert property (op_start |-> !$past(busy))
    else $error("operation started while busy");
  chk_busy_follow: assert property (op_start |-> ##[0:2] busy)
    else $error("busy did not follow start");
  chk_wel_clear: assert property ($fell(busy) |-> ##[0:1] !write_enable_latch)
    else $error("write enable not cleared at finish");
  chk_mem_busy: assert property (mem_we |-> busy)
    else $error("memory written while not busy");
  chk_erase_align: assert property (op_start && op_kind != 2'h0 |-> (op_addr & ~(op_kind == 2'h1 ?
    SECT_MASK : op_kind == 2'h2 ? BLK32_MASK : BLK64_MASK)) == 24'h0)
    else $error("erase address not aligned");
  chk_read_section: assert property (read_step && !wrap_config_bits[0] |=>
    read_addr[23:6] == $past(read_addr[23:6]))
    else $error("wrapped read left its section");
endmodule : spfpe_core_sva

bind spfpe_core spfpe_core_sva u_spfpe_core_sva (.core_clk(core_clk), .rst_n(rst_n),
  .target_protected(target_protected), .read_step(read_step),
  .write_enable_latch(write_enable_latch), .busy(busy), .wrap_config_bits(wrap_config_bits),
  .read_addr(read_addr), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
  .mem_we(mem_we));

//--- spfpe_host_model.sv
// Host controller model driving frames onto the serial link
`timescale 1ns/1ps
module spfpe_host_model (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic [3:0] spi_io_in
);
  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_io_in = 4'h5;
  end
  task automatic put(input logic [3:0] v);
    spi_io_in = v;
    #24 spi_clk = 1'b1;
    #24 spi_clk = 1'b0;
  endtask : put
  // Opcode on one line, rest on four when quad; extra bits break the byte boundary
  task automatic xfer(input logic [7:0] b[$], input bit quad, input int extra);
    spi_cs_n = 1'b0;
    #24;
    foreach (b[i])
    begin
      if (quad && i > 0)
      begin
        put(b[i][7:4]);
        put(b[i][3:0]);
      end
      else
        for (int k = 7; k >= 0; k--)
          put({{3{~b[i][k]}}, b[i][k]});
    end
    repeat (extra) put(4'h1);
    #24 spi_cs_n = 1'b1;
    spi_io_in = ~spi_io_in;
    #300;
  endtask : xfer
endmodule : spfpe_host_model

//--- spfpe_pkg.sv
// Shared constants for the flash program, erase and wrap block
package spfpe_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRAP_SET = 8'h77;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_BITS = 24;
  localparam int WRAP_DUMMY_BITS = 24;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_LO = 5;
  localparam logic [2:0] WRAP_CFG_RESET = 3'h1;
  localparam logic [23:0] SECT_MASK = 24'hfff000;
  localparam logic [23:0] BLK32_MASK = 24'hff8000;
  localparam logic [23:0] BLK64_MASK = 24'hff0000;
  // ----------------------------------------------------------------
  // Operation kinds and times
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPFPE_OP_PROG, SPFPE_OP_SECT, SPFPE_OP_B32, SPFPE_OP_B64}
    spfpe_op_t;
  localparam int CLK_MHZ = 40;
  localparam int PAGE_PROG_US = 3000;
  localparam int SECT_ERASE_US = 400000;
  localparam int BLK32_ERASE_US = 1600000;
  localparam int BLK64_ERASE_US = 2000000;
endpackage : spfpe_pkg

//--- tb_spi_flash_program_erase_wrap.sv
// Self-checking bench for the program, erase and wrap core
`timescale 1ns/1ps
module tb_spi_flash_program_erase_wrap;
  import spfpe_pkg::*;
  logic core_clk, rst_n, quad_enable, wel_set, target_protected, read_step;
  logic spi_clk, spi_cs_n, write_enable_latch, busy, op_start, page_wr_en, mem_we;
  logic [3:0] spi_io_in;
  logic [23:0] read_start_addr, read_addr, op_addr, mem_addr, a_seen;
  logic [2:0] wrap_config_bits;
  logic [1:0] op_kind, k_seen;
  logic [7:0] page_wr_idx, page_wr_data, mem_wdata;
  logic [15:0] pg_q[$];
  logic [7:0] f[$];
  logic [7:0] eop[3] = '{OP_SECT_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE};
  logic [23:0] emsk[3] = '{SECT_MASK, BLK32_MASK, BLK64_MASK};
  int mismatches, cmp_count, n_start, n_ff;
  spfpe_host_model u_spfpe_host_model (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_io_in(spi_io_in));
  spfpe_core #(.PAGE_PROG_CYC(20), .SECT_ERASE_CYC(20), .BLK32_ERASE_CYC(20),
    .BLK64_ERASE_CYC(20)) u_spfpe_core (.core_clk(core_clk), .rst_n(rst_n),
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_io_in(spi_io_in),
    .quad_enable(quad_enable), .wel_set(wel_set), .target_protected(target_protected),
    .read_start_addr(read_start_addr), .read_step(read_step),
    .write_enable_latch(write_enable_latch), .busy(busy),
    .wrap_config_bits(wrap_config_bits), .read_addr(read_addr), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .page_wr_en(page_wr_en),
    .page_wr_idx(page_wr_idx), .page_wr_data(page_wr_data), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Output monitor and helpers
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (op_start === 1'b1)
    begin
      n_start++;
      k_seen = op_kind;
      a_seen = op_addr;
    end
    if (page_wr_en === 1'b1)
      pg_q.push_back({page_wr_idx, page_wr_data});
    if (mem_we === 1'b1 && mem_wdata === ERASED_BYTE)
      n_ff++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic wel_pulse;
    cyc(1);
    wel_set = 1'b1;
    cyc(1);
    wel_set = 1'b0;
  endtask : wel_pulse
  task automatic wait_idle;
    cyc(2);
    for (int i = 0; i < 10000 && busy !== 1'b0; i++)
      cyc(1);
    chk(busy, 1'b0);
  endtask : wait_idle
  task automatic rd_walk(input logic [23:0] s, input int n, input logic [23:0] e);
    cyc(1);
    read_start_addr = s;
    cyc(2);
    read_step = 1'b1;
    cyc(n);
    chk(read_addr, e);
    read_step = 1'b0;
    cyc(1);
  endtask : rd_walk
  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  initial
  begin
    #2000000;
    mismatches++;
    test_done;
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    quad_enable = 1'b0;
    wel_set = 1'b0;
    target_protected = 1'b0;
    read_start_addr = 24'h000000;
    read_step = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(3);
    chk(wrap_config_bits, WRAP_CFG_RESET);
    chk(write_enable_latch, 1'b0);
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      f = '{OP_WRAP_SET, 8'h00, 8'h00, 8'h00, {1'b1, m[1:0], 1'b0, 4'hf}};
      u_spfpe_host_model.xfer(f, 1'b0, 0);
      chk(wrap_config_bits, {m[1:0], 1'b0});
      rd_walk(24'h001203 + (m << 16), 8 << m, 24'h001203 + (m << 16));
    end
    f = '{OP_WRAP_SET, 8'h00, 8'h00, 8'h00, 8'h5f};
    u_spfpe_host_model.xfer(f, 1'b0, 0);
    chk(wrap_config_bits, 3'h5);
    rd_walk(24'h0012fd, 8, 24'h001305);
    $display("test wrap done");
    f = '{OP_PAGE_PROG, 8'h00, 8'h01, 8'h00, 8'h5a};
    u_spfpe_host_model.xfer(f, 1'b0, 0);
    wel_pulse();
    u_spfpe_host_model.xfer(f, 1'b0, 3);
    cyc(1);
    target_protected = 1'b1;
    u_spfpe_host_model.xfer(f, 1'b0, 0);
    cyc(1);
    target_protected = 1'b0;
    f[0] = OP_QUAD_PROG;
    u_spfpe_host_model.xfer(f, 1'b1, 0);
    chk(n_start, 0);
    chk(write_enable_latch, 1'b1);
    $display("test refusal done");
    pg_q.delete();
    f = '{OP_PAGE_PROG, 8'h00, 8'h01, 8'hfe, 8'h11, 8'h22, 8'h33};
    u_spfpe_host_model.xfer(f, 1'b0, 0);
    wait_idle();
    chk(n_start, 1);
    chk(k_seen, 2'h0);
    chk(pg_q.size(), 3);
    chk(pg_q[0], 16'hfe11);
    chk(pg_q[1], 16'hff22);
    chk(pg_q[2], 16'h0033);
    chk(write_enable_latch, 1'b0);
    cyc(1);
    quad_enable = 1'b1;
    wel_pulse();
    pg_q.delete();
    f = '{OP_QUAD_PROG, 8'h00, 8'h02, 8'h10, 8'ha5};
    u_spfpe_host_model.xfer(f, 1'b1, 0);
    wait_idle();
    chk(n_start, 2);
    chk(pg_q[0], 16'h10a5);
    $display("test program done");
    for (int e = 0; e < 3; e++)
    begin
      wel_pulse();
      n_ff = 0;
      f = '{eop[e], 8'h12, 8'h34, 8'h56};
      u_spfpe_host_model.xfer(f, 1'b0, 0);
      chk(k_seen, e + 1);
      chk(a_seen, 24'h123456 & emsk[e]);
      if (e == 0)
      begin
        wait_idle();
        chk(n_ff, 4096);
        chk(write_enable_latch, 1'b0);
      end
      else
      begin
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        cyc(3);
        chk(busy, 1'b0);
        chk(wrap_config_bits, WRAP_CFG_RESET);
      end
    end
    $display("test erase done");
    test_done();
  end
endmodule : tb_spi_flash_program_erase_wrap
